// ### rtl/sotr_pkg.sv
/*
 * constants of the self-test, interface config and offset trim register bank.
 * assumes one 50 MHz clock, 8-bit register addresses and 8-bit register data.
 */
package sotr_pkg;
	// ==========================================
	// register offsets
	localparam logic [7:0] ADDR_GYR_ST   = 8'h6e;
	localparam logic [7:0] ADDR_NONVOLATILE_INTERFACE_CONFIG  = 8'h70;
	localparam logic [7:0] ADDR_ACC_X    = 8'h71;
	localparam logic [7:0] ADDR_ACC_Y    = 8'h72;
	localparam logic [7:0] ADDR_ACC_Z    = 8'h73;
	localparam logic [7:0] ADDR_GYR_XL   = 8'h74;
	localparam logic [7:0] ADDR_GYR_YL   = 8'h75;
	localparam logic [7:0] ADDR_GYR_ZL   = 8'h76;
	localparam logic [7:0] ADDR_GYR_HI   = 8'h77;
	localparam logic [7:0] ADDR_COMMAND  = 8'h7e;
	// ==========================================
	// fields and values
	localparam int         ST_DONE_BIT   = 0;
	localparam int         ST_OK_LSB     = 1;
	localparam int         CF_SPI_BIT    = 0;
	localparam int         CF_WDT_SEL    = 1;
	localparam int         CF_WDT_EN     = 2;
	localparam int         CF_ACC_OFF    = 3;
	localparam int         HI_GYR_OFF    = 6;
	localparam int         HI_GAIN_EN    = 7;
	localparam logic [7:0] RESET_VAL     = 8'h00;
	localparam logic [7:0] CMD_NVM_STORE = 8'ha0;
	// ==========================================
	// timing
	localparam int         CLK_PERIOD_NS = 20;
	localparam int         WDT_SHORT_NS  = 1250000;
	localparam int         WDT_LONG_NS   = 40000000;
	localparam int         WDT_SHORT_CYC = WDT_SHORT_NS / CLK_PERIOD_NS;
	localparam int         WDT_LONG_CYC  = WDT_LONG_NS / CLK_PERIOD_NS;
	localparam int         WDT_W         = 21;
endpackage

// ### rtl/sotr_regs.sv
/*
 * self-test status, interface config and offset trim register bank with
 * offset adders, I2C watchdog and NVM store request.
 * assumes a register port from the primary serial interface on clk, and
 * sensor samples, self-test results and NVM loads on the same clock.
 */
`timescale 1ns/1ps
module sotr_regs import sotr_pkg::*; #(
	parameter int WDT_SHORT = WDT_SHORT_CYC,
	parameter int WDT_LONG  = WDT_LONG_CYC
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// register port
	input  wire logic                  wrEn,
	input  wire logic                  rdEn,
	input  wire logic [7:0]            addr,
	input  wire logic [7:0]            wrData,
	output logic      [7:0]            rdData,
	// self-test results
	input  wire logic                  stStart,
	input  wire logic                  stDone,
	input  wire logic [2:0]            stOk,
	// nvm
	input  wire logic                  nvmLoad,
	input  wire logic [7:0][7:0]       nvmLoadData,
	output logic                       nvmStoreReq,
	output logic      [7:0][7:0]       nvmImage,
	// interface and watchdog
	input  wire logic                  autoCfgMode,
	input  wire logic                  serialDataInPin,
	output logic                       spiSelect,
	output logic                       wdtTimeout,
	// sensor data
	input  wire logic                  sampleValid,
	input  wire logic [2:0][15:0]      accFiltIn,
	input  wire logic [2:0][15:0]      accRawIn,
	input  wire logic [2:0][15:0]      gyrFiltIn,
	input  wire logic [2:0][15:0]      gyrRawIn,
	output logic                       sampleOutValid,
	output logic      [2:0][15:0]      accFiltOut,
	output logic      [2:0][15:0]      accRawOut,
	output logic      [2:0][15:0]      gyrFiltOut,
	output logic      [2:0][15:0]      gyrRawOut,
	output logic                       gainCompEn
);
	typedef struct packed {
		logic [3:0]       stat;
		logic [3:0]       conf;
		logic [2:0][7:0]  accTrim;
		logic [2:0][7:0]  gyrLow;
		logic [7:0]       gyrHigh;
		logic [7:0]       rdData;
		logic             nvmStore;
		logic [WDT_W-1:0] wdtCnt;
		logic             wdtTimeout;
		logic             sdiMeta;
		logic             sdiSync;
		logic             spiSel;
		logic             gainEn;
		logic             outValid;
		logic [2:0][15:0] accFilt;
		logic [2:0][15:0] accRaw;
		logic [2:0][15:0] gyrFilt;
		logic [2:0][15:0] gyrRaw;
	} sotr_state_t;

	sotr_state_t s_r;
	sotr_state_t s_nxt;

	// ==========================================
	// helpers
	// saturate rather than wrap so a large trim cannot flip the sign
	function automatic logic [15:0] addTrim(input logic [15:0] d, input logic [9:0] t);
		logic signed [16:0] sum;
		sum = $signed({d[15], d}) + $signed({{7{t[9]}}, t});
		if (sum > 17'sh07fff)
			return 16'h7fff;
		else if (sum < -17'sh08000)
			return 16'h8000;
		else
			return sum[15:0];
	endfunction

	function automatic logic [9:0] gyrTrim(input sotr_state_t st, input int ax);
		return {st.gyrHigh[2*ax +: 2], st.gyrLow[ax]};
	endfunction

	function automatic logic [9:0] accTrimW(input sotr_state_t st, input int ax);
		return {{2{st.accTrim[ax][7]}}, st.accTrim[ax]};
	endfunction

	logic [WDT_W-1:0] wdtLimit;

	// ==========================================
	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.nvmStore = 1'b0;
		s_nxt.wdtTimeout = 1'b0;
		s_nxt.outValid = sampleValid;
		// self-test status; a done in the same cycle as a restart wins
		if (stStart)
			s_nxt.stat = 4'h0;
		if (stDone) begin
			s_nxt.stat[ST_DONE_BIT] = 1'b1;
			s_nxt.stat[ST_OK_LSB +: 3] = stOk;
		end
		// register writes
		if (wrEn) begin
			unique case (addr)
				ADDR_NONVOLATILE_INTERFACE_CONFIG: s_nxt.conf = wrData[3:0];
				ADDR_ACC_X:   s_nxt.accTrim[0] = wrData;
				ADDR_ACC_Y:   s_nxt.accTrim[1] = wrData;
				ADDR_ACC_Z:   s_nxt.accTrim[2] = wrData;
				ADDR_GYR_XL:  s_nxt.gyrLow[0] = wrData;
				ADDR_GYR_YL:  s_nxt.gyrLow[1] = wrData;
				ADDR_GYR_ZL:  s_nxt.gyrLow[2] = wrData;
				ADDR_GYR_HI:  s_nxt.gyrHigh = wrData;
				ADDR_COMMAND: s_nxt.nvmStore = (wrData == CMD_NVM_STORE);
				default: ;
			endcase
		end
		// nvm restore overrides a write in the same cycle
		if (nvmLoad) begin
			s_nxt.conf = nvmLoadData[0][3:0];
			s_nxt.accTrim = nvmLoadData[3:1];
			s_nxt.gyrLow = nvmLoadData[6:4];
			s_nxt.gyrHigh = nvmLoadData[7];
		end
		// reads; command reads zero
		if (rdEn) begin
			unique case (addr)
				ADDR_GYR_ST:  s_nxt.rdData = {4'h0, s_r.stat};
				ADDR_NONVOLATILE_INTERFACE_CONFIG: s_nxt.rdData = {4'h0, s_r.conf};
				ADDR_ACC_X:   s_nxt.rdData = s_r.accTrim[0];
				ADDR_ACC_Y:   s_nxt.rdData = s_r.accTrim[1];
				ADDR_ACC_Z:   s_nxt.rdData = s_r.accTrim[2];
				ADDR_GYR_XL:  s_nxt.rdData = s_r.gyrLow[0];
				ADDR_GYR_YL:  s_nxt.rdData = s_r.gyrLow[1];
				ADDR_GYR_ZL:  s_nxt.rdData = s_r.gyrLow[2];
				ADDR_GYR_HI:  s_nxt.rdData = s_r.gyrHigh;
				default:      s_nxt.rdData = 8'h00;
			endcase
		end
		// interface select and gain enable
		s_nxt.spiSel = autoCfgMode & s_r.conf[CF_SPI_BIT];
		s_nxt.gainEn = s_r.gyrHigh[HI_GAIN_EN];
		// watchdog: counts while data-in is held low in I2C mode
		s_nxt.sdiMeta = serialDataInPin;
		s_nxt.sdiSync = s_r.sdiMeta;
		if (!s_r.conf[CF_WDT_EN] || s_r.spiSel || s_r.sdiSync) begin
			s_nxt.wdtCnt = '0;
		end else if (s_r.wdtCnt == wdtLimit - 1'b1) begin
			s_nxt.wdtCnt = '0;
			s_nxt.wdtTimeout = 1'b1;
		end else begin
			s_nxt.wdtCnt = s_r.wdtCnt + 1'b1;
		end
		// offset adders
		if (sampleValid) begin
			for (int i = 0; i < 3; i++) begin
				s_nxt.accFilt[i] = s_r.conf[CF_ACC_OFF] ? addTrim(accFiltIn[i], accTrimW(s_r, i)) : accFiltIn[i];
				s_nxt.accRaw[i] = s_r.conf[CF_ACC_OFF] ? addTrim(accRawIn[i], accTrimW(s_r, i)) : accRawIn[i];
				s_nxt.gyrFilt[i] = s_r.gyrHigh[HI_GYR_OFF] ? addTrim(gyrFiltIn[i], gyrTrim(s_r, i)) : gyrFiltIn[i];
				s_nxt.gyrRaw[i] = s_r.gyrHigh[HI_GYR_OFF] ? addTrim(gyrRawIn[i], gyrTrim(s_r, i)) : gyrRawIn[i];
			end
		end
	end

	assign wdtLimit = s_r.conf[CF_WDT_SEL] ? WDT_W'(WDT_LONG) : WDT_W'(WDT_SHORT);

	always_ff @(posedge clk) begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// ==========================================
	// outputs
	assign rdData = s_r.rdData;
	assign nvmStoreReq = s_r.nvmStore;
	assign nvmImage = {s_r.gyrHigh, s_r.gyrLow, s_r.accTrim, {4'h0, s_r.conf}};
	assign spiSelect = s_r.spiSel;
	assign wdtTimeout = s_r.wdtTimeout;
	assign sampleOutValid = s_r.outValid;
	assign accFiltOut = s_r.accFilt;
	assign accRawOut = s_r.accRaw;
	assign gyrFiltOut = s_r.gyrFilt;
	assign gyrRawOut = s_r.gyrRaw;
	assign gainCompEn = s_r.gainEn;

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_DONE_SET: assert property (stDone |=> s_r.stat[ST_DONE_BIT])
		else $error("done flag not set");
	AST_AXES_OK: assert property (stDone |=> s_r.stat[3:1] == $past(stOk))
		else $error("axis flags wrong");
	AST_SPI_SEL: assert property (##1 spiSelect == $past(autoCfgMode && s_r.conf[CF_SPI_BIT]))
		else $error("spi select wrong");
	AST_WDT_PERIOD: assert property (wdtTimeout |-> $past(s_r.wdtCnt) == $past(wdtLimit) - 1'b1)
		else $error("watchdog period wrong");
	AST_WDT_OFF: assert property (!s_r.conf[CF_WDT_EN] |=> !wdtTimeout)
		else $error("watchdog fired while off");
	AST_ACC_ADD: assert property (sampleValid && s_r.conf[CF_ACC_OFF]
		|=> accRawOut[0] == addTrim($past(accRawIn[0]), $past(accTrimW(s_r, 0))))
		else $error("accel offset not added");
	AST_ACC_WR: assert property (wrEn && addr == ADDR_ACC_Y && !nvmLoad |=> s_r.accTrim[1] == $past(wrData))
		else $error("accel trim write lost");
	AST_GYR_ADD: assert property (sampleValid && s_r.gyrHigh[HI_GYR_OFF]
		|=> gyrFiltOut[2] == addTrim($past(gyrFiltIn[2]), {$past(s_r.gyrHigh[5:4]), $past(s_r.gyrLow[2])}))
		else $error("gyro offset not added");
	AST_GYR_PASS: assert property (sampleValid && !s_r.gyrHigh[HI_GYR_OFF] |=> gyrRawOut[1] == $past(gyrRawIn[1]))
		else $error("gyro data altered");
	AST_GAIN: assert property (##1 gainCompEn == $past(s_r.gyrHigh[HI_GAIN_EN]))
		else $error("gain enable wrong");
	AST_STORE: assert property (nvmStoreReq |-> $past(wrEn && addr == ADDR_COMMAND && wrData == CMD_NVM_STORE))
		else $error("spurious nvm store");
	AST_STORE_GO: assert property (wrEn && addr == ADDR_COMMAND && wrData == CMD_NVM_STORE |=> nvmStoreReq)
		else $error("nvm store missed");

	// ==========================================
	// checks: status, config, gyro high, gain enable and interface
	AST_ST_CLEAR: assert property (stStart && !stDone |=> s_r.stat == 4'h0)
		else $error("status not cleared");
	AST_ST_HOLD: assert property (!stStart && !stDone |=> $stable(s_r.stat))
		else $error("status changed without a test");
	AST_SPI_I2C: assert property (!autoCfgMode |=> !spiSelect)
		else $error("spi selected outside auto mode");
	AST_CONF_WR: assert property (wrEn && addr == ADDR_NONVOLATILE_INTERFACE_CONFIG && !nvmLoad
		|=> s_r.conf == $past(wrData[3:0]))
		else $error("config write lost");
	AST_GYR_HI_WR: assert property (wrEn && addr == ADDR_GYR_HI && !nvmLoad
		|=> s_r.gyrHigh == $past(wrData))
		else $error("gyro high write lost");
	AST_GAIN_OFF: assert property (!s_r.gyrHigh[HI_GAIN_EN] |=> !gainCompEn)
		else $error("gain enable without its bit");

	// ==========================================
	// checks: watchdog
	// the count trails the pin by the two sync flops, so the period is checked on the count
	AST_WDT_SHORT: assert property (wdtTimeout && !$past(s_r.conf[CF_WDT_SEL])
		|-> $past(s_r.wdtCnt) == WDT_W'(WDT_SHORT - 1))
		else $error("short watchdog period wrong");
	AST_WDT_LONG: assert property (wdtTimeout && $past(s_r.conf[CF_WDT_SEL])
		|-> $past(s_r.wdtCnt) == WDT_W'(WDT_LONG - 1))
		else $error("long watchdog period wrong");
	AST_WDT_SPI: assert property (spiSelect |=> !wdtTimeout)
		else $error("watchdog fired in spi mode");
	AST_WDT_PIN: assert property (s_r.sdiSync |=> !wdtTimeout && s_r.wdtCnt == '0)
		else $error("watchdog ran with the pin high");
	AST_WDT_CLR: assert property (!s_r.conf[CF_WDT_EN] |=> s_r.wdtCnt == '0)
		else $error("watchdog count kept while off");

	// ==========================================
	// checks: offset adders
	AST_ACC_FILT: assert property (sampleValid && s_r.conf[CF_ACC_OFF]
		|=> accFiltOut[1] == addTrim($past(accFiltIn[1]), {{2{$past(s_r.accTrim[1][7])}}, $past(s_r.accTrim[1])}))
		else $error("accel filtered offset not added");
	AST_ACC_RAW_Z: assert property (sampleValid && s_r.conf[CF_ACC_OFF]
		|=> accRawOut[2] == addTrim($past(accRawIn[2]), {{2{$past(s_r.accTrim[2][7])}}, $past(s_r.accTrim[2])}))
		else $error("accel z offset not added");
	AST_ACC_PASS: assert property (sampleValid && !s_r.conf[CF_ACC_OFF]
		|=> accFiltOut[2] == $past(accFiltIn[2]) && accRawOut[1] == $past(accRawIn[1]))
		else $error("accel data altered");
	AST_GYR_RAW: assert property (sampleValid && s_r.gyrHigh[HI_GYR_OFF]
		|=> gyrRawOut[0] == addTrim($past(gyrRawIn[0]), {$past(s_r.gyrHigh[1:0]), $past(s_r.gyrLow[0])}))
		else $error("gyro x offset not added");
	AST_GYR_FILT_Y: assert property (sampleValid && s_r.gyrHigh[HI_GYR_OFF]
		|=> gyrFiltOut[1] == addTrim($past(gyrFiltIn[1]), {$past(s_r.gyrHigh[3:2]), $past(s_r.gyrLow[1])}))
		else $error("gyro y offset not added");
	AST_OUT_VALID: assert property (##1 sampleOutValid == $past(sampleValid))
		else $error("output valid not one cycle after input");
	AST_OUT_HOLD: assert property (!sampleValid
		|=> $stable(accFiltOut) && $stable(accRawOut) && $stable(gyrFiltOut) && $stable(gyrRawOut))
		else $error("outputs changed between samples");

	// ==========================================
	// checks: nvm and reads
	AST_NVM_LOAD: assert property (nvmLoad
		|=> nvmImage == {$past(nvmLoadData[7:1]), 4'h0, $past(nvmLoadData[0][3:0])})
		else $error("nvm load not applied");
	AST_STORE_ONLY: assert property (wrEn && addr == ADDR_COMMAND && wrData != CMD_NVM_STORE
		|=> !nvmStoreReq)
		else $error("store on another command");
	AST_RD_CMD: assert property (rdEn && addr == ADDR_COMMAND |=> rdData == 8'h00)
		else $error("command register read not zero");
	AST_RD_CONF: assert property (rdEn && addr == ADDR_NONVOLATILE_INTERFACE_CONFIG |=> rdData == {4'h0, $past(s_r.conf)})
		else $error("config read wrong");
	AST_RD_ST: assert property (rdEn && addr == ADDR_GYR_ST |=> rdData == {4'h0, $past(s_r.stat)})
		else $error("status read wrong");
	AST_RD_HOLD: assert property (!rdEn |=> $stable(rdData))
		else $error("read data moved without a read");

	// ==========================================
	// covers
	COV_STORE: cover property (wrEn && addr == ADDR_COMMAND ##1 nvmStoreReq);
	COV_WDT: cover property (wdtTimeout);
	COV_ST: cover property (stDone && stOk == 3'h7);
	COV_SAT: cover property (sampleOutValid && accRawOut[0] == 16'h7fff);
	COV_GYR_OFF: cover property (sampleOutValid && s_r.gyrHigh[HI_GYR_OFF]);
endmodule

// ### sim/sotr_host.sv
/*
 * host model of the primary serial interface side of the trim bank.
 * assumes strobes are taken at the rising edge; drives at the falling edge.
 */
`timescale 1ns/1ps
module sotr_host import sotr_pkg::*; (
	// clock
	input  wire logic       clk,
	// register port
	output logic            wrEn,
	output logic            rdEn,
	output logic      [7:0] addr,
	output logic      [7:0] wrData
);
	// ==========
	// bus cycles
	initial begin
		wrEn = 1'b0;
		rdEn = 1'b0;
		addr = 8'h00;
		wrData = 8'h00;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wrEn = w;
		rdEn = !w;
		addr = a;
		wrData = d;
		@(negedge clk);
		// idle bus never shows a stale value
		wrEn = 1'b0;
		rdEn = 1'b0;
		addr = ~a;
		wrData = ~d;
	endtask
	task automatic storeNvm();
		xfer(1'b1, ADDR_COMMAND, CMD_NVM_STORE);
	endtask
endmodule

// ### sim/tb.sv
/*
 * self-checking bench of the trim bank with host model and queue scoreboard.
 * assumes the watchdog limits are shortened to 20 and 50 cycles.
 */
`timescale 1ns/1ps
module tb import sotr_pkg::*; ;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic             wrEn, rdEn, stStart, stDone, nvmLoad, autoCfgMode, serialDataInPin, sampleValid;
	logic             nvmStoreReq, spiSelect, wdtTimeout, sampleOutValid, gainCompEn, rdSeen;
	logic [7:0]       addr, wrData, rdData;
	logic [2:0]       stOk;
	logic [7:0][7:0]  nvmLoadData, nvmImage, img;
	logic [2:0][15:0] accFiltIn, accRawIn, gyrFiltIn, gyrRawIn, accFiltOut, accRawOut, gyrFiltOut, gyrRawOut;
	logic [7:0]       rdQ[$];
	logic [191:0]     smQ[$];
	logic [31:0]      seed = 32'hc38e;
	int               miscompares = 0;
	int               compares = 0;
	always #10 clk = ~clk;
	sotr_host host (.clk(clk), .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData));
	sotr_regs #(.WDT_SHORT(20), .WDT_LONG(50)) DUT (.clk(clk), .rst(rst), .wrEn(wrEn), .rdEn(rdEn),
		.addr(addr), .wrData(wrData), .rdData(rdData), .stStart(stStart), .stDone(stDone), .stOk(stOk),
		.nvmLoad(nvmLoad), .nvmLoadData(nvmLoadData), .nvmStoreReq(nvmStoreReq), .nvmImage(nvmImage),
		.autoCfgMode(autoCfgMode), .serialDataInPin(serialDataInPin), .spiSelect(spiSelect),
		.wdtTimeout(wdtTimeout), .sampleValid(sampleValid), .accFiltIn(accFiltIn), .accRawIn(accRawIn),
		.gyrFiltIn(gyrFiltIn), .gyrRawIn(gyrRawIn), .sampleOutValid(sampleOutValid),
		.accFiltOut(accFiltOut), .accRawOut(accRawOut), .gyrFiltOut(gyrFiltOut),
		.gyrRawOut(gyrRawOut), .gainCompEn(gainCompEn));
	// ==========
	// helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] sat(input int v);
		return (v > 32767) ? 16'h7fff : (v < -32768) ? 16'h8000 : 16'(v);
	endfunction
	task automatic chk(input string n, input logic [191:0] s, input logic [191:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rdQ.push_back(e);
		host.xfer(1'b0, a, 8'h00);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
	endtask
	task automatic sample();
		logic [191:0] in, e;
		int           v;
		{accFiltIn, accRawIn, gyrFiltIn, gyrRawIn} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
		in = {accFiltIn, accRawIn, gyrFiltIn, gyrRawIn};
		for (int j = 0; j < 12; j++) begin
			v = $signed(in[16*j+:16]);
			if (j >= 6 && img[0][CF_ACC_OFF]) v += $signed(img[1+j%3]);
			if (j < 6 && img[7][HI_GYR_OFF]) v += $signed({img[7][2*(j%3)+:2], img[4+j%3]});
			e[16*j+:16] = sat(v);
		end
		smQ.push_back(e);
		pulse(sampleValid);
	endtask
	// ==========
	// result watcher, reads land one cycle after the strobe
	always @(posedge clk) rdSeen <= rdEn;
	always @(negedge clk) begin
		if (rdSeen === 1'b1) chk("rdData", 192'(rdData), 192'(rdQ.pop_front()));
		if (sampleOutValid === 1'b1) chk("sample", {accFiltOut, accRawOut, gyrFiltOut, gyrRawOut}, smQ.pop_front());
	end
	initial begin
		// the tests need under 2000 cycles
		#100us;
		miscompares++;
		finish_test();
	end
	// ==========
	// main sequence
	initial begin
		{stStart, stDone, nvmLoad, autoCfgMode, sampleValid, stOk} = '0;
		{accFiltIn, accRawIn, gyrFiltIn, gyrRawIn, nvmLoadData} = '0;
		serialDataInPin = 1'b1;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		for (int a = 8'h6e; a <= 8'h7f; a++) rd(8'(a), 8'h00);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			img[i] = 8'(rnd());
			host.xfer(1'b1, ADDR_NONVOLATILE_INTERFACE_CONFIG + 8'(i), img[i]);
		end
		img[0][7:4] = 4'h0;
		host.xfer(1'b1, ADDR_GYR_ST, 8'hff);
		host.xfer(1'b1, 8'h6f, 8'hff);
		for (int i = 0; i < 8; i++) rd(ADDR_NONVOLATILE_INTERFACE_CONFIG + 8'(i), img[i]);
		rd(ADDR_GYR_ST, 8'h00);
		$display("test write done");
		for (int k = 0; k < 4; k++) begin
			img[0][CF_ACC_OFF] = k[0];
			img[7][HI_GYR_OFF] = k[1];
			img[7][HI_GAIN_EN] = k[0];
			host.xfer(1'b1, ADDR_NONVOLATILE_INTERFACE_CONFIG, img[0]);
			host.xfer(1'b1, ADDR_GYR_HI, img[7]);
			// gain enable follows the register one cycle later
			@(negedge clk);
			chk("gain", 192'(gainCompEn), 192'(k[0]));
			repeat (4) sample();
		end
		$display("test sample done");
		for (int k = 0; k < 8; k++) begin
			pulse(stStart);
			rd(ADDR_GYR_ST, 8'h00);
			stOk = 3'(k);
			pulse(stDone);
			rd(ADDR_GYR_ST, {4'h0, 3'(k), 1'b1});
		end
		$display("test selftest done");
		host.storeNvm();
		chk("store", 192'(nvmStoreReq), 192'(1));
		chk("image", 192'(nvmImage), 192'(img));
		nvmLoadData = {rnd(), rnd()};
		pulse(nvmLoad);
		img = nvmLoadData;
		img[0][7:4] = 4'h0;
		for (int i = 0; i < 8; i++) rd(ADDR_NONVOLATILE_INTERFACE_CONFIG + 8'(i), img[i]);
		pulse(rst);
		for (int i = 0; i < 8; i++) rd(ADDR_NONVOLATILE_INTERFACE_CONFIG + 8'(i), 8'h00);
		$display("test nvm done");
		for (int k = 0; k < 4; k++) begin
			int n;
			autoCfgMode = (k > 1);
			host.xfer(1'b1, ADDR_NONVOLATILE_INTERFACE_CONFIG, (k == 0) ? 8'h04 : (k == 1) ? 8'h06 : (k == 2) ? 8'h00 : 8'h05);
			@(negedge clk);
			chk("spi", 192'(spiSelect), 192'(k == 3));
			serialDataInPin = 1'b0;
			n = 0;
			while (wdtTimeout !== 1'b1 && n < 120) begin
				@(negedge clk);
				n++;
			end
			serialDataInPin = 1'b1;
			chk("wdt", 192'((k > 1) ? n == 120 : n >= 20 + 30 * k && n <= 24 + 30 * k), 192'(1));
		end
		$display("test watchdog done");
		repeat (4) @(negedge clk);
		chk("drain", 192'(rdQ.size() + smQ.size()), 192'(0));
		finish_test();
	end
endmodule
